// *** rim_cfg.svh ***
// constants for the relay io matrix and event logic
`ifndef RIM_CFG_SVH
`define RIM_CFG_SVH
// ==========================================
// sizes
`define RIM_NUM_DI   8
`define RIM_NUM_STG  4
`define RIM_NUM_RLY  8
`define RIM_NUM_LED  16
`define RIM_NUM_DST  26
`define RIM_NUM_REC  12
`define RIM_NUM_LOG  16
`define RIM_NUM_EV   144
// ==========================================
// timing: 1 ms tick from an 8 ns clock
`define RIM_TICK_NS  1000000
`define RIM_CLK_NS   8
`define RIM_TICK_CYC (`RIM_TICK_NS / `RIM_CLK_NS)
`define RIM_DLY_MAX_MS 1800000
// ==========================================
// register byte offsets
`define RIM_CTRL     12'h000
`define RIM_DI_POL   12'h004
`define RIM_DI_STAT  12'h008
`define RIM_DO_POL   12'h00C
`define RIM_DO_STAT  12'h010
`define RIM_LED_COL  12'h014
`define RIM_LED_STAT 12'h018
`define RIM_LIN      12'h01C
`define RIM_LIN_MODE 12'h020
`define RIM_LOUT     12'h024
`define RIM_GST_LO   12'h028
`define RIM_GST_HI   12'h02C
`define RIM_GQ_LO    12'h030
`define RIM_GQ_HI    12'h034
`define RIM_SG_EN    12'h038
`define RIM_SG_ACT   12'h03C
`define RIM_EVM_DI   12'h040
`define RIM_EVM_LINR 12'h044
`define RIM_EVM_LINF 12'h048
`define RIM_EVM_LOR  12'h04C
`define RIM_EVM_LOF  12'h050
`define RIM_EVLOG_N  12'h054
`define RIM_BLK_STAT 12'h058
`define RIM_BLK_SEL  12'h080
`define RIM_DI_ACT   12'h0C0
`define RIM_DI_REL   12'h0E0
`define RIM_CONN     12'h100
`define RIM_LSEL     12'h180
`define RIM_EVLOG    12'h200
`define RIM_OPREC    12'h300
// ==========================================
// control bits and reset values
`define RIM_CTRL_LCLR  0
`define RIM_CTRL_RCLR  1
`define RIM_SG_EN_RST  8'h01
`define RIM_DO_POL_RST 8'h00
`define RIM_LED_COL_RST 16'h0000
`endif

// *** rim_pkg.sv ***
// types shared by the relay io matrix
package rim_pkg;
    typedef logic [31:0] rim_word_t;
    typedef logic [20:0] rim_dly_t;
    typedef logic [2:0]  rim_grp_t;
    typedef logic [15:0] rim_meas_t;
endpackage

// *** rim_top.sv ***
// relay io matrix, logical signals, blocking, event log and operation records
// Operation
// - non-latched connection drops in the same cycle its source goes inactive
// - latched connection holds until source inactive and latch clear received
// - panel clear in single-line view clears latches with inactive source
// - logical inputs default to hold; in hold mode they change only on user writes
// - pulse-mode logical input goes 1 on write, back to 0 next cycle
// - 32 logical in, 32 logical out, 64 goose status, 64 goose quality
// - goose quality bit reads 0 when good, 1 when bad
// - per stage twelve operation records, cleared on clear command
// - general event log has no clear; clear requests leave it untouched
// - each event source has a mask, off at reset; only masked logged
// - digital input polarity selects sensed level or its inverse
// - digital input activation and release delays, 0 to 1800 s, 1 ms step
// - output polarity open or closed at rest, open at rest after reset
// - only setting group one enabled after reset of eight groups
// - stage blockable by inputs, logical signals, objects, other stages
// - blocked stage drives an indication routable to outputs
// - stage signals routable to relays, start/trip leds or 16 user leds
// - each of the 16 user leds has green/yellow colour, green at reset
// - logic gate activation raises no event; only logical outputs do
// - logical inputs and outputs raise masked rise and fall events
// - closed-at-rest outputs fall open on full reset only
// - group one highest priority, group eight lowest
`include "rim_cfg.svh"
module rim_top import rim_pkg::*; #(
    parameter int unsigned TICK_CYC = `RIM_TICK_CYC
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // field and logic engine inputs
    input  wire logic [7:0]  di_raw_in,
    input  wire logic [31:0] logical_out_in,
    input  wire logic [3:0]  obj_status_in,
    input  wire logic [3:0]  stage_pickup_in,
    input  wire logic [3:0]  stage_operate_in,
    input  wire logic [63:0] stage_meas_in,
    input  wire logic [7:0]  sg_req_in,
    input  wire logic [63:0] goose_status_in,
    input  wire logic [63:0] goose_rx_quality_bit_in,
    // panel
    input  wire logic        panel_switch_we_in,
    input  wire logic [4:0]  panel_switch_idx_in,
    input  wire logic        panel_switch_val_in,
    input  wire logic        panel_clear_in,
    input  wire logic        mimic_view_in,
    // outputs
    output logic      [7:0]  relay_out,
    output logic      [15:0] led_user_out,
    output logic             led_start_out,
    output logic             led_trip_out,
    output logic      [15:0] led_yellow_out,
    output logic      [31:0] logical_in_out,
    output logic      [3:0]  stage_blocked_out,
    output logic      [2:0]  sg_active_out,
    output logic      [7:0]  di_status_out
);
    localparam int ND = `RIM_NUM_DST;
    localparam int NR = `RIM_NUM_REC;
    localparam int NS = `RIM_NUM_STG;
    localparam int NE = `RIM_NUM_EV;

    // ==========================================
    // state
    logic [16:0]  tick_cnt_r, tick_cnt_nxt;
    logic [23:0]  ms_r, ms_nxt;
    logic [7:0]   di_pol_r, di_pol_nxt, di_stat_r, di_stat_nxt;
    rim_dly_t     di_act_r [8], di_act_nxt [8], di_rel_r [8], di_rel_nxt [8];
    rim_dly_t     di_cnt_r [8], di_cnt_nxt [8];
    logic [7:0]   do_pol_r, do_pol_nxt;
    logic [15:0]  led_col_r, led_col_nxt, evm_di_r, evm_di_nxt;
    logic [31:0]  lin_r, lin_nxt, lin_mode_r, lin_mode_nxt, lout_prev_r;
    logic [31:0]  evm_linr_r, evm_linr_nxt, evm_linf_r, evm_linf_nxt;
    logic [31:0]  evm_lor_r, evm_lor_nxt, evm_lof_r, evm_lof_nxt;
    logic [7:0]   sg_en_r, sg_en_nxt;
    rim_grp_t     sg_act_r, sg_act_nxt;
    logic [31:0]  blk_sel_r [NS], blk_sel_nxt [NS];
    logic [3:0]   blk_r, blk_nxt;
    logic [31:0]  conn_r [ND], conn_nxt [ND], lsel_r [ND], lsel_nxt [ND];
    logic [31:0]  lat_r [ND], lat_nxt [ND];
    logic [NE-1:0] pend_r, pend_nxt;
    logic [31:0]  log_r [`RIM_NUM_LOG], log_nxt [`RIM_NUM_LOG];
    logic [15:0]  log_n_r, log_n_nxt;
    rim_meas_t    pre_r [NS], pre_nxt [NS];
    logic [3:0]   pk_prev_r, op_prev_r;
    logic [3:0]   rec_wp_r [NS], rec_wp_nxt [NS];
    logic [31:0]  rec_val_r [NS*NR], rec_val_nxt [NS*NR];
    logic [31:0]  rec_inf_r [NS*NR], rec_inf_nxt [NS*NR];
    logic [31:0]  rd_data_r, rd_data;
    logic         rd_err_r, rd_err;

    // ==========================================
    // combinational helpers
    logic         wr, tick, lclr, rclr, lin_wr;
    logic [31:0]  src;
    logic [7:0]   di_lv;
    logic [ND-1:0] dst_act;
    logic [NE-1:0] ev_hit;
    logic         g_any;
    logic [7:0]   g_idx;

    // zero-wait slave; read data latched in the setup cycle
    assign wr          = psel_in & penable_in & pwrite_in;
    assign pready_out  = 1'b1;
    assign prdata_out  = rd_data_r;
    assign pslverr_out = rd_err_r & psel_in & penable_in;
    assign tick        = (tick_cnt_r == 17'(TICK_CYC - 1));
    assign lin_wr      = wr & (paddr_in == `RIM_LIN);
    assign rclr        = wr & (paddr_in == `RIM_CTRL) & pwdata_in[`RIM_CTRL_RCLR];
    assign lclr        = (panel_clear_in & mimic_view_in)
                       | (wr & (paddr_in == `RIM_CTRL) & pwdata_in[`RIM_CTRL_LCLR]);
    assign di_lv       = di_raw_in ^ di_pol_r;
    // matrix sources; blocked bits come from flops to avoid a loop
    assign src = {blk_r, stage_operate_in, stage_pickup_in, obj_status_in,
                  logical_out_in[3:0], lin_r[3:0], di_stat_r};

    // destination drive: latched term keeps it after the source drops
    always_comb begin
        for (int d = 0; d < ND; d++) begin
            dst_act[d] = (|(conn_r[d] & src)) | (|lat_r[d]);
            lat_nxt[d] = conn_r[d] & lsel_r[d] & (src | (lat_r[d] & ~{32{lclr}}));
        end
    end
    assign relay_out      = dst_act[7:0] ^ do_pol_r;
    assign led_user_out   = dst_act[23:8];
    assign led_start_out  = dst_act[24];
    assign led_trip_out   = dst_act[25];
    assign led_yellow_out = led_col_r;
    assign logical_in_out = lin_r;
    assign stage_blocked_out = blk_r;
    assign sg_active_out  = sg_act_r;
    assign di_status_out  = di_stat_r;

    // configuration registers written from the bus
    always_comb begin
        di_pol_nxt = di_pol_r;
        do_pol_nxt = do_pol_r;
        led_col_nxt = led_col_r;
        lin_mode_nxt = lin_mode_r;
        sg_en_nxt = sg_en_r;
        evm_di_nxt = evm_di_r;
        evm_linr_nxt = evm_linr_r;
        evm_linf_nxt = evm_linf_r;
        evm_lor_nxt = evm_lor_r;
        evm_lof_nxt = evm_lof_r;
        blk_sel_nxt = blk_sel_r;
        di_act_nxt = di_act_r;
        di_rel_nxt = di_rel_r;
        conn_nxt = conn_r;
        lsel_nxt = lsel_r;
        if (wr) begin
            unique case (paddr_in)
                `RIM_DI_POL:   di_pol_nxt = pwdata_in[7:0];
                `RIM_DO_POL:   do_pol_nxt = pwdata_in[7:0];
                `RIM_LED_COL:  led_col_nxt = pwdata_in[15:0];
                `RIM_LIN_MODE: lin_mode_nxt = pwdata_in;
                `RIM_SG_EN:    sg_en_nxt = pwdata_in[7:0];
                `RIM_EVM_DI:   evm_di_nxt = pwdata_in[15:0];
                `RIM_EVM_LINR: evm_linr_nxt = pwdata_in;
                `RIM_EVM_LINF: evm_linf_nxt = pwdata_in;
                `RIM_EVM_LOR:  evm_lor_nxt = pwdata_in;
                `RIM_EVM_LOF:  evm_lof_nxt = pwdata_in;
                default: ;
            endcase
            for (int i = 0; i < NS; i++)
                if (paddr_in == `RIM_BLK_SEL + 12'(4*i)) blk_sel_nxt[i] = pwdata_in;
            for (int i = 0; i < 8; i++) begin
                if (paddr_in == `RIM_DI_ACT + 12'(4*i)) di_act_nxt[i] = pwdata_in[20:0];
                if (paddr_in == `RIM_DI_REL + 12'(4*i)) di_rel_nxt[i] = pwdata_in[20:0];
            end
            for (int d = 0; d < ND; d++) begin
                if (paddr_in == `RIM_CONN + 12'(4*d)) conn_nxt[d] = pwdata_in;
                if (paddr_in == `RIM_LSEL + 12'(4*d)) lsel_nxt[d] = pwdata_in;
            end
        end
    end

    // digital input filter and timebase
    always_comb begin
        tick_cnt_nxt = tick ? 17'h0_0000 : tick_cnt_r + 17'h0_0001;
        ms_nxt = tick ? ms_r + 24'h00_0001 : ms_r;
        di_stat_nxt = di_stat_r;
        for (int i = 0; i < 8; i++) begin
            di_cnt_nxt[i] = di_cnt_r[i];
            if (di_lv[i] == di_stat_r[i]) begin
                di_cnt_nxt[i] = '0;
            end else if (di_cnt_r[i] >= (di_lv[i] ? di_act_r[i] : di_rel_r[i])) begin
                di_stat_nxt[i] = di_lv[i];
                di_cnt_nxt[i] = '0;
            end else if (tick) begin
                di_cnt_nxt[i] = di_cnt_r[i] + 21'h00_0001;
            end
        end
    end

    // logical inputs, blocking, setting groups
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            lin_nxt[i] = lin_mode_r[i] ? 1'b0 : lin_r[i];
            if (lin_wr) lin_nxt[i] = pwdata_in[i];
            if (panel_switch_we_in && panel_switch_idx_in == 5'(i))
                lin_nxt[i] = panel_switch_val_in;
        end
        for (int s = 0; s < NS; s++)
            blk_nxt[s] = |(blk_sel_r[s] & src);
        sg_act_nxt = sg_act_r;
        for (int g = 7; g >= 0; g--)
            if (sg_req_in[g] & sg_en_r[g]) sg_act_nxt = 3'(g);
    end

    // event capture; gate outputs reach here only as logical outputs
    always_comb begin
        ev_hit = {lout_prev_r & ~logical_out_in & evm_lof_r,
                  logical_out_in & ~lout_prev_r & evm_lor_r,
                  lin_r & ~lin_nxt & evm_linf_r,
                  lin_nxt & ~lin_r & evm_linr_r,
                  di_stat_r & ~di_stat_nxt & evm_di_r[15:8],
                  di_stat_nxt & ~di_stat_r & evm_di_r[7:0]};
        g_any = 1'b0;
        g_idx = 8'h00;
        for (int i = NE - 1; i >= 0; i--)
            if (pend_r[i]) begin
                g_any = 1'b1;
                g_idx = 8'(i);
            end
        pend_nxt = pend_r;
        if (g_any) pend_nxt[g_idx] = 1'b0;
        pend_nxt = pend_nxt | ev_hit; // new event wins over its own drain
        log_nxt = log_r;
        log_n_nxt = log_n_r;
        // no clear path exists for the log
        if (g_any) begin
            log_nxt[log_n_r[3:0]] = {ms_r, g_idx};
            log_n_nxt = log_n_r + 16'h0001;
        end
    end

    // operation records: trigger on operate rise, prefault held from pickup
    always_comb begin
        rec_wp_nxt = rec_wp_r;
        rec_val_nxt = rec_val_r;
        rec_inf_nxt = rec_inf_r;
        pre_nxt = pre_r;
        if (rclr) begin
            for (int s = 0; s < NS; s++) rec_wp_nxt[s] = 4'h0;
            for (int e = 0; e < NS*NR; e++) begin
                rec_val_nxt[e] = 32'h0000_0000;
                rec_inf_nxt[e] = 32'h0000_0000;
            end
        end
        for (int s = 0; s < NS; s++) begin
            if (stage_pickup_in[s] & ~pk_prev_r[s]) pre_nxt[s] = stage_meas_in[16*s +: 16];
            if (stage_operate_in[s] & ~op_prev_r[s]) begin
                rec_val_nxt[s*NR + int'(rec_wp_nxt[s])] = {pre_r[s], stage_meas_in[16*s +: 16]};
                rec_inf_nxt[s*NR + int'(rec_wp_nxt[s])] = {5'h00, sg_act_r, ms_r};
                rec_wp_nxt[s] = (rec_wp_nxt[s] == 4'(NR - 1)) ? 4'h0 : rec_wp_nxt[s] + 4'h1;
            end
        end
    end

    // read decode; unmapped addresses answer with pslverr
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (paddr_in)
            `RIM_CTRL:     rd_data = 32'h0000_0000;
            `RIM_DI_POL:   rd_data = {24'h00_0000, di_pol_r};
            `RIM_DI_STAT:  rd_data = {24'h00_0000, di_stat_r};
            `RIM_DO_POL:   rd_data = {24'h00_0000, do_pol_r};
            `RIM_DO_STAT:  rd_data = {24'h00_0000, relay_out};
            `RIM_LED_COL:  rd_data = {16'h0000, led_col_r};
            `RIM_LED_STAT: rd_data = {14'h0000, dst_act[25:8]};
            `RIM_LIN:      rd_data = lin_r;
            `RIM_LIN_MODE: rd_data = lin_mode_r;
            `RIM_LOUT:     rd_data = logical_out_in;
            `RIM_GST_LO:   rd_data = goose_status_in[31:0];
            `RIM_GST_HI:   rd_data = goose_status_in[63:32];
            `RIM_GQ_LO:    rd_data = goose_rx_quality_bit_in[31:0];
            `RIM_GQ_HI:    rd_data = goose_rx_quality_bit_in[63:32];
            `RIM_SG_EN:    rd_data = {24'h00_0000, sg_en_r};
            `RIM_SG_ACT:   rd_data = {29'h0000_0000, sg_act_r};
            `RIM_EVM_DI:   rd_data = {16'h0000, evm_di_r};
            `RIM_EVM_LINR: rd_data = evm_linr_r;
            `RIM_EVM_LINF: rd_data = evm_linf_r;
            `RIM_EVM_LOR:  rd_data = evm_lor_r;
            `RIM_EVM_LOF:  rd_data = evm_lof_r;
            `RIM_EVLOG_N:  rd_data = {16'h0000, log_n_r};
            `RIM_BLK_STAT: rd_data = {28'h000_0000, blk_r};
            default:       rd_err = 1'b1;
        endcase
        for (int i = 0; i < NS; i++)
            if (paddr_in == `RIM_BLK_SEL + 12'(4*i)) {rd_err, rd_data} = {1'b0, blk_sel_r[i]};
        for (int i = 0; i < 8; i++) begin
            if (paddr_in == `RIM_DI_ACT + 12'(4*i)) {rd_err, rd_data} = {1'b0, 11'h000, di_act_r[i]};
            if (paddr_in == `RIM_DI_REL + 12'(4*i)) {rd_err, rd_data} = {1'b0, 11'h000, di_rel_r[i]};
        end
        for (int d = 0; d < ND; d++) begin
            if (paddr_in == `RIM_CONN + 12'(4*d)) {rd_err, rd_data} = {1'b0, conn_r[d]};
            if (paddr_in == `RIM_LSEL + 12'(4*d)) {rd_err, rd_data} = {1'b0, lsel_r[d]};
        end
        for (int i = 0; i < `RIM_NUM_LOG; i++)
            if (paddr_in == `RIM_EVLOG + 12'(4*i)) {rd_err, rd_data} = {1'b0, log_r[i]};
        for (int e = 0; e < NS*NR; e++) begin
            if (paddr_in == `RIM_OPREC + 12'(8*e)) {rd_err, rd_data} = {1'b0, rec_val_r[e]};
            if (paddr_in == `RIM_OPREC + 12'(8*e + 4)) {rd_err, rd_data} = {1'b0, rec_inf_r[e]};
        end
    end

    // all flops; only the full system reset returns relays to open at rest
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_cnt_r <= '0;
            ms_r <= '0;
            di_pol_r <= '0;
            di_stat_r <= '0;
            do_pol_r <= `RIM_DO_POL_RST;
            led_col_r <= `RIM_LED_COL_RST;
            lin_r <= '0;
            lin_mode_r <= '0;
            lout_prev_r <= '0;
            evm_di_r <= '0;
            evm_linr_r <= '0;
            evm_linf_r <= '0;
            evm_lor_r <= '0;
            evm_lof_r <= '0;
            sg_en_r <= `RIM_SG_EN_RST;
            sg_act_r <= '0;
            blk_r <= '0;
            pend_r <= '0;
            log_n_r <= '0;
            pk_prev_r <= '0;
            op_prev_r <= '0;
            rd_data_r <= '0;
            rd_err_r <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                di_act_r[i] <= '0;
                di_rel_r[i] <= '0;
                di_cnt_r[i] <= '0;
            end
            for (int s = 0; s < NS; s++) begin
                blk_sel_r[s] <= '0;
                pre_r[s] <= '0;
                rec_wp_r[s] <= '0;
            end
            for (int d = 0; d < ND; d++) begin
                conn_r[d] <= '0;
                lsel_r[d] <= '0;
                lat_r[d] <= '0;
            end
            for (int i = 0; i < `RIM_NUM_LOG; i++) log_r[i] <= '0;
            for (int e = 0; e < NS*NR; e++) begin
                rec_val_r[e] <= '0;
                rec_inf_r[e] <= '0;
            end
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            ms_r <= ms_nxt;
            di_pol_r <= di_pol_nxt;
            di_stat_r <= di_stat_nxt;
            do_pol_r <= do_pol_nxt;
            led_col_r <= led_col_nxt;
            lin_r <= lin_nxt;
            lin_mode_r <= lin_mode_nxt;
            lout_prev_r <= logical_out_in;
            evm_di_r <= evm_di_nxt;
            evm_linr_r <= evm_linr_nxt;
            evm_linf_r <= evm_linf_nxt;
            evm_lor_r <= evm_lor_nxt;
            evm_lof_r <= evm_lof_nxt;
            sg_en_r <= sg_en_nxt;
            sg_act_r <= sg_act_nxt;
            blk_r <= blk_nxt;
            pend_r <= pend_nxt;
            log_n_r <= log_n_nxt;
            pk_prev_r <= stage_pickup_in;
            op_prev_r <= stage_operate_in;
            if (psel_in & ~penable_in) begin
                rd_data_r <= rd_data;
                rd_err_r <= rd_err;
            end
            di_act_r <= di_act_nxt;
            di_rel_r <= di_rel_nxt;
            di_cnt_r <= di_cnt_nxt;
            blk_sel_r <= blk_sel_nxt;
            pre_r <= pre_nxt;
            rec_wp_r <= rec_wp_nxt;
            conn_r <= conn_nxt;
            lsel_r <= lsel_nxt;
            lat_r <= lat_nxt;
            log_r <= log_nxt;
            rec_val_r <= rec_val_nxt;
            rec_inf_r <= rec_inf_nxt;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_lin_pulse;
        lin_mode_r[1] && lin_r[1] && !lin_wr && !panel_switch_we_in;
    endsequence
    property p_nonlatch_drop;
        lsel_r[0] == 32'h0000_0000 && $stable(lsel_r[0]) && !(|(conn_r[0] & src)) |-> !dst_act[0];
    endproperty
    a_nonlatch_drop: assert property (p_nonlatch_drop) else $error("relay 0 active without cause");
    property p_latch_hold;
        lat_r[1][8] && !lclr && conn_r[1][8] && lsel_r[1][8] |=> lat_r[1][8] && dst_act[1];
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch lost without clear");
    property p_latch_clear;
        lclr && !src[8] |=> !lat_r[1][8];
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");
    property p_lin_pulse;
        s_lin_pulse |=> !lin_r[1];
    endproperty
    a_lin_pulse: assert property (p_lin_pulse) else $error("pulse input stayed high");
    property p_lin_hold;
        !lin_mode_r[0] && !lin_wr && !panel_switch_we_in |=> $stable(lin_r[0]);
    endproperty
    a_lin_hold: assert property (p_lin_hold) else $error("hold input changed alone");
    property p_log_noclear;
        rclr |=> log_n_r >= $past(log_n_r);
    endproperty
    a_log_noclear: assert property (p_log_noclear) else $error("event log cleared");
    property p_di_wait;
        di_lv[2] != di_stat_r[2] && di_cnt_r[2] < (di_lv[2] ? di_act_r[2] : di_rel_r[2]) |=> $stable(di_stat_r[2]);
    endproperty
    a_di_wait: assert property (p_di_wait) else $error("input changed before delay");
    property p_block;
        |(blk_sel_r[1] & src) |=> blk_r[1] ##0 stage_blocked_out[1];
    endproperty
    a_block: assert property (p_block) else $error("stage not blocked");
    property p_sg_prio;
        sg_req_in[0] && sg_en_r[0] |=> sg_act_r == 3'h0;
    endproperty
    a_sg_prio: assert property (p_sg_prio) else $error("group one lost priority");
    property p_masked_ev;
        !pend_r[16] && !(lin_nxt[0] && !lin_r[0] && evm_linr_r[0]) |=> !pend_r[16];
    endproperty
    a_masked_ev: assert property (p_masked_ev) else $error("unmasked event pending");
endmodule // rim_top

// *** rim_field_model.sv ***
// field side model: digital input levels and received goose bits
module rim_field_model (
    // levels chosen by the bench
    input  wire logic [7:0]  lvl_in,
    // toward the block
    output logic      [7:0]  di_raw_out,
    output logic      [63:0] gst_out,
    output logic      [63:0] gq_out
);
    // contacts follow the chosen levels directly
    assign di_raw_out = lvl_in;
    // fixed frame; quality set means that message was bad
    assign gst_out = 64'h0000_00a5_0000_005a;
    assign gq_out  = 64'h0000_0003_0000_00c0;
endmodule // rim_field_model

// *** relay_io_matrix_event_logic_tb_top.sv ***
// bench for the relay io matrix over its apb port
`include "rim_cfg.svh"
module relay_io_matrix_event_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, se;
    logic pready_out, pslverr_out, led_start_out, led_trip_out, panel_clear_in = 0, mimic_view_in = 0;
    logic panel_switch_we_in = 0, panel_switch_val_in = 0;
    logic [4:0] panel_switch_idx_in = 0;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, rd, logical_in_out, logical_out_in = 0;
    logic [7:0] di_raw_in, sg_req_in = 0, relay_out, di_status_out, lvl = 0;
    logic [63:0] goose_status_in, goose_rx_quality_bit_in, stage_meas_in = 0;
    logic [15:0] led_user_out, led_yellow_out;
    logic [3:0] stage_blocked_out, obj_status_in = 0, stage_pickup_in = 0, stage_operate_in = 0;
    logic [2:0] sg_active_out;
    int errors = 0, compares = 0, cyc = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    // short tick keeps the millisecond timers cheap to simulate
    rim_top #(.TICK_CYC(10)) dut (.*);
    rim_field_model fld (.lvl_in(lvl), .di_raw_out(di_raw_in), .gst_out(goose_status_in),
                         .gq_out(goose_rx_quality_bit_in));
    task automatic close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // a hang is cut short far beyond the expected run length
    always @(posedge ref_clk_in) if (++cyc == 5000) begin
        errors++;
        close_out();
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
        @(posedge ref_clk_in);
        penable_in <= 1;
        do @(posedge ref_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        se = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        bus(1, a, d);
        @(negedge ref_clk_in);
    endtask
    task automatic rc(string n, logic [11:0] a, logic [31:0] e);
        bus(0, a, 0);
        chk(n, e, rd);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        reset_n_in <= 1;
        rc("sg_en", `RIM_SG_EN, 1);
        rc("do_pol", `RIM_DO_POL, 0);
        rc("led_col", `RIM_LED_COL, 0);
        rc("ev_mask", `RIM_EVM_LINR, 0);
        rc("gq_lo", `RIM_GQ_LO, 32'h0000_00c0);
        rc("gq_hi", `RIM_GQ_HI, 32'h0000_0003);
        rc("hole", 12'h05C, 0);
        chk("slverr", 1, se);
        $display("reset and readback test done");
        // relay0 plain, relay1 latched, both fed by logical input 0
        wr(`RIM_CONN, 32'h0000_0100);
        wr(`RIM_CONN + 4, 32'h0000_0100);
        wr(`RIM_LSEL + 4, 32'h0000_0100);
        wr(`RIM_LIN, 1);
        chk("relay", 3, relay_out);
        wr(`RIM_LIN, 0);
        chk("relay", 2, relay_out);
        @(posedge ref_clk_in) {panel_clear_in, mimic_view_in} <= 2'b11;
        @(posedge ref_clk_in) panel_clear_in <= 0;
        repeat (2) @(negedge ref_clk_in);
        chk("relay", 0, relay_out);
        wr(`RIM_DO_POL, 32'h0000_0080);
        chk("relay", 8'h80, relay_out);
        $display("matrix test done");
        wr(`RIM_EVM_LINR, 2);
        wr(`RIM_LIN_MODE, 2);
        wr(`RIM_LIN, 2);
        chk("lin", 2, logical_in_out);
        @(posedge ref_clk_in) {panel_switch_we_in, panel_switch_idx_in, panel_switch_val_in} <= 7'h47;
        @(posedge ref_clk_in) panel_switch_we_in <= 0;
        repeat (3) @(negedge ref_clk_in);
        chk("lin", 8, logical_in_out);
        // stage 1 blocked by logical input 3, shown on user led 0
        wr(`RIM_BLK_SEL + 4, 32'h0000_0800);
        wr(`RIM_CONN + 32, 32'h2000_0000);
        wr(`RIM_LED_COL, 3);
        chk("blocked", 2, stage_blocked_out);
        chk("led_user", 1, led_user_out);
        chk("yellow", 3, led_yellow_out);
        wr(`RIM_SG_EN, 8'hff);
        @(posedge ref_clk_in) sg_req_in <= 8'h06;
        repeat (3) @(negedge ref_clk_in);
        chk("sg_act", 1, sg_active_out);
        @(posedge ref_clk_in) sg_req_in <= 8'h07;
        repeat (3) @(negedge ref_clk_in);
        chk("sg_act", 0, sg_active_out);
        $display("logical and group test done");
        wr(`RIM_DI_ACT + 8, 3);
        wr(`RIM_EVM_DI, 1);
        wr(`RIM_CONN + 96, 32'h0010_0000);
        wr(`RIM_CONN + 100, 32'h0100_0000);
        @(posedge ref_clk_in) lvl <= 8'h05;
        repeat (15) @(negedge ref_clk_in);
        chk("di", 1, di_status_out);
        repeat (40) @(negedge ref_clk_in);
        chk("di", 5, di_status_out);
        // stage 0: pickup captures the prefault value, operate the fault value
        @(posedge ref_clk_in) {stage_pickup_in, stage_meas_in} <= {4'h1, 64'h1234};
        @(posedge ref_clk_in) {stage_operate_in, stage_meas_in} <= {4'h1, 64'h5678};
        rc("rec", `RIM_OPREC, 32'h1234_5678);
        chk("start_trip", 3, {led_start_out, led_trip_out});
        rc("ev_n", `RIM_EVLOG_N, 2);
        wr(`RIM_CTRL, 3);
        rc("ev_n", `RIM_EVLOG_N, 2);
        rc("rec", `RIM_OPREC, 0);
        wr(`RIM_DI_POL, 2);
        repeat (30) @(negedge ref_clk_in);
        chk("di", 7, di_status_out);
        $display("input and event test done");
        close_out();
    end
endmodule // relay_io_matrix_event_logic_tb_top
